// [hdl/sensor_config_pkg.sv]
// package with object addresses, field layouts and reset values of the config bank
package sensor_config_pkg;
	localparam logic [15:0] IDX_LANGUAGE = 16'h2300;
	localparam logic [15:0] IDX_OPERATING = 16'h6000;
	localparam logic [15:0] IDX_POSITION = 16'h6004;
	localparam logic [15:0] IDX_OP_STATUS = 16'h6500;
	localparam logic [15:0] IDX_STEP_NM = 16'h6501;
	localparam logic [15:0] IDX_FAULT = 16'h2070;
	localparam logic [7:0] SUB_LANGUAGE = 8'h01;
	localparam logic [7:0] SUB_BACKLIGHT = 8'h02;
	localparam logic [7:0] SUB_CONTRAST = 8'h03;
	localparam logic [7:0] SUB_PW_ENABLE = 8'h04;
	localparam logic [7:0] SUB_PW_VALUE = 8'h05;
	localparam logic [7:0] SUB_HEATER = 8'h06;
	localparam logic [7:0] SUB_VEL_FAULT = 8'h03;
	localparam logic [15:0] IDX_MSG = 16'h2310;
	localparam logic [7:0] SUB_MSG_CMD = 8'h00;
	localparam logic [7:0] SUB_MSG_COUNT = 8'h01;
	localparam logic [7:0] SUB_MSG_FIRST = 8'h10;
	localparam logic [15:0] IDX_DIAG = 16'h2320;
	localparam logic [7:0] SUB_DIAG_MODE = 8'h01;
	localparam logic [7:0] SUB_DIAG_COUNT = 8'h02;
	localparam int VF_LAST_ZERO_BIT = 0;
	localparam int VF_SUPPRESS_BIT = 2;
	localparam int VF_DELAY_BIT = 3;
	localparam logic [7:0] VF_MAX = 8'h0D;
	localparam logic [7:0] VF_RESET = 8'h0D;
	localparam logic [7:0] VF_MASK = 8'h0D;
	localparam int DIR_BIT = 3;
	localparam logic [15:0] OP_MASK = 16'h0008;
	localparam logic [7:0] LANG_MAX = 8'h04;
	localparam logic [7:0] LANG_RESET = 8'h00;
	localparam logic [7:0] BACKLIGHT_RESET = 8'h00;
	localparam logic [7:0] CONTRAST_MAX = 8'h02;
	localparam logic [7:0] CONTRAST_RESET = 8'h01;
	localparam logic [7:0] PW_ENABLE_RESET = 8'h00;
	localparam logic [15:0] PW_MAX = 16'h270F;
	localparam logic [15:0] PW_RESET = 16'h0000;
	localparam logic [7:0] HEATER_RESET = 8'h00;
	localparam logic signed [31:0] POS_MIN = -32'sd999999;
	localparam logic signed [31:0] POS_MAX = 32'sd999999;
	localparam int MSG_DEPTH = 25;
	localparam logic [7:0] MSG_OCCURRENCE = 8'h01;
	localparam int BACKLIGHT_MIN = 10;
	localparam longint CLK_HZ = 100000000;
	localparam longint BACKLIGHT_CYCLES = longint'(BACKLIGHT_MIN) * 60 * CLK_HZ;
	localparam logic [7:0] HEAT_STD_ON_C = 8'd10;
	localparam logic [7:0] HEAT_STD_OFF_C = 8'd15;
	localparam logic [7:0] HEAT_EXT_ON_C = 8'd30;
	localparam logic [7:0] HEAT_EXT_OFF_C = 8'd35;
	localparam logic [1:0] CMD_ACK_ONE = 2'h0;
	localparam logic [1:0] CMD_DEL_ONE = 2'h1;
	localparam logic [1:0] CMD_ACK_ALL = 2'h2;
	localparam logic [1:0] CMD_DEL_ALL = 2'h3;

	typedef enum logic [1:0]
	{
		MSG_INFO = 2'b00,
		MSG_WARNING = 2'b01,
		MSG_ERROR = 2'b10,
		MSG_SEVERE = 2'b11
	} msg_type_t;

	typedef struct packed
	{
		logic valid;
		logic acked;
		msg_type_t kind;
		logic [11:0] number;
		logic [7:0] occurrence;
	} msg_entry_t;

	typedef struct packed
	{
		logic wr;
		logic rd;
		logic [15:0] index;
		logic [7:0] sub;
		logic [31:0] wdata;
	} obj_req_t;
endpackage : sensor_config_pkg

// [hdl/sensor_config_object_bank.sv]
// configuration and status object bank of the distance sensor
// Behaviour
// - velocity fault bit0: 0 hold last value, 1 force zero; bit1 reads 0
// - velocity fault bit2 set suppresses velocity status indication
// - velocity fault bit3 set delays signalling of a velocity fault
// - language code 0..4, default 0
// - backlight 0 turns off after ten minutes, 1 keeps it on
// - contrast 0 low, 1 medium, 2 high; starts medium
// - password holds 0000..9999, default 0000
// - password only effective while activation flag is 1, default off
// - heater 0 selects 10..15 C band, 1 selects 30..35 C band
// - heater setting always accessible, drives hardware only with heater fitted
// - operating word bit3 is counting direction; other bits unused
// - read-only status word mirrors operating word direction bit
// - signed position within +-999999, byte 0 least significant
// - measurement step reported in nanometres
// - status messages kept automatically in 25-entry ring, oldest overwritten
// - ring emptied at power-up reset
// - entries carry type code and internal error number
// - occurrence count of every entry is 1
// - acknowledge or delete one entry or all entries
// - leaving diagnostics stops recording and clears its contents
// - diagnostics never stalls object access
// - velocity fault byte accepts 0..13, default 13
`timescale 1ns/1ps
`default_nettype none
module sensor_config_object_bank
	import sensor_config_pkg::*;
#(
	parameter longint BACKLIGHT_TIMEOUT = BACKLIGHT_CYCLES,
	parameter bit HEATER_FITTED = 1'b1
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire obj_req_t req,
	output logic [31:0] rdata,
	output logic rvalid,
	output logic wr_error,
	input wire logic signed [31:0] position_in,
	input wire logic [31:0] resolution_nm,
	input wire logic velocity_fault,
	input wire logic signed [31:0] velocity_in,
	input wire logic fault_delay_done,
	input wire logic msg_push,
	input wire msg_type_t msg_kind,
	input wire logic [11:0] msg_number,
	input wire logic key_activity,
	input wire logic [7:0] temperature_c,
	input wire logic diag_sample,
	output logic signed [31:0] velocity_out,
	output logic velocity_status,
	output logic count_negative,
	output logic [2:0] language,
	output logic backlight_on,
	output logic [1:0] contrast,
	output logic password_required,
	output logic [15:0] password,
	output logic heater_on
);
	logic [7:0] vel_fault, next_vel_fault;
	logic [7:0] lang_r, next_lang_r;
	logic [7:0] backlight, next_backlight;
	logic [7:0] contrast_r, next_contrast_r;
	logic [7:0] pw_enable, next_pw_enable;
	logic [15:0] pw_value, next_pw_value;
	logic [7:0] heater_sel, next_heater_sel;
	logic [15:0] op_param, next_op_param;
	logic signed [31:0] position, next_position;
	logic [31:0] step_nm, next_step_nm;
	msg_entry_t ring [MSG_DEPTH];
	msg_entry_t next_ring [MSG_DEPTH];
	logic [4:0] wr_ptr, next_wr_ptr;
	logic [4:0] msg_count, next_msg_count;
	logic diag_mode, next_diag_mode;
	logic [15:0] diag_count, next_diag_count;
	logic [63:0] light_timer, next_light_timer;
	logic light_on, next_light_on;
	logic heat, next_heat;
	logic signed [31:0] vel_hold, next_vel_hold;
	logic [31:0] next_rdata;
	logic next_rvalid, next_wr_error;

	function automatic logic [4:0] ring_inc(input logic [4:0] p);
		ring_inc = (p == 5'(MSG_DEPTH - 1)) ? 5'h00 : p + 5'h01;
	endfunction : ring_inc

	function automatic logic match(input obj_req_t r, input logic [15:0] i, input logic [7:0] s);
		match = (r.index == i) && (r.sub == s);
	endfunction : match

	always_comb
	begin
		next_vel_fault = vel_fault;
		next_lang_r = lang_r;
		next_backlight = backlight;
		next_contrast_r = contrast_r;
		next_pw_enable = pw_enable;
		next_pw_value = pw_value;
		next_heater_sel = heater_sel;
		next_op_param = op_param;
		next_diag_mode = diag_mode;
		next_wr_error = 1'b0;
		if (req.wr)
		begin
			next_wr_error = 1'b1;
			// range check on velocity fault byte
			if (match(req, IDX_FAULT, SUB_VEL_FAULT) && req.wdata[7:0] <= VF_MAX)
			begin
				next_vel_fault = req.wdata[7:0] & VF_MASK;
				next_wr_error = 1'b0;
			end
			if (match(req, IDX_LANGUAGE, SUB_LANGUAGE) && req.wdata[7:0] <= LANG_MAX)
			begin
				next_lang_r = req.wdata[7:0];
				next_wr_error = 1'b0;
			end
			if (match(req, IDX_LANGUAGE, SUB_BACKLIGHT) && req.wdata[7:1] == 7'h00)
			begin
				next_backlight = req.wdata[7:0];
				next_wr_error = 1'b0;
			end
			if (match(req, IDX_LANGUAGE, SUB_CONTRAST) && req.wdata[7:0] <= CONTRAST_MAX)
			begin
				next_contrast_r = req.wdata[7:0];
				next_wr_error = 1'b0;
			end
			if (match(req, IDX_LANGUAGE, SUB_PW_ENABLE) && req.wdata[7:1] == 7'h00)
			begin
				next_pw_enable = req.wdata[7:0];
				next_wr_error = 1'b0;
			end
			if (match(req, IDX_LANGUAGE, SUB_PW_VALUE) && req.wdata[15:0] <= PW_MAX)
			begin
				next_pw_value = req.wdata[15:0];
				next_wr_error = 1'b0;
			end
			if (match(req, IDX_LANGUAGE, SUB_HEATER) && req.wdata[7:1] == 7'h00)
			begin
				next_heater_sel = req.wdata[7:0];
				next_wr_error = 1'b0;
			end
			if (match(req, IDX_OPERATING, 8'h00))
			begin
				next_op_param = req.wdata[15:0] & OP_MASK;
				next_wr_error = 1'b0;
			end
			if (match(req, IDX_DIAG, SUB_DIAG_MODE))
			begin
				next_diag_mode = req.wdata[0];
				next_wr_error = 1'b0;
			end
			if (match(req, IDX_MSG, SUB_MSG_CMD))
			begin
				next_wr_error = 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			vel_fault <= VF_RESET;
			lang_r <= LANG_RESET;
			backlight <= BACKLIGHT_RESET;
			contrast_r <= CONTRAST_RESET;
			pw_enable <= PW_ENABLE_RESET;
			pw_value <= PW_RESET;
			heater_sel <= HEATER_RESET;
			op_param <= 16'h0000;
			diag_mode <= 1'b0;
			wr_error <= 1'b0;
		end
		else
		begin
			vel_fault <= next_vel_fault;
			lang_r <= next_lang_r;
			backlight <= next_backlight;
			contrast_r <= next_contrast_r;
			pw_enable <= next_pw_enable;
			pw_value <= next_pw_value;
			heater_sel <= next_heater_sel;
			op_param <= next_op_param;
			diag_mode <= next_diag_mode;
			wr_error <= next_wr_error;
		end
	end

	// status message ring
	always_comb
	begin
		next_ring = ring;
		next_wr_ptr = wr_ptr;
		next_msg_count = msg_count;
		if (req.wr && match(req, IDX_MSG, SUB_MSG_CMD))
		begin
			unique case (req.wdata[9:8])
				CMD_ACK_ONE:
				begin
					if (req.wdata[4:0] < 5'(MSG_DEPTH))
						next_ring[req.wdata[4:0]].acked = 1'b1;
				end
				CMD_DEL_ONE:
				begin
					if (req.wdata[4:0] < 5'(MSG_DEPTH) && ring[req.wdata[4:0]].valid)
					begin
						next_ring[req.wdata[4:0]] = '0;
						next_msg_count = msg_count - 5'h01;
					end
				end
				CMD_ACK_ALL:
				begin
					for (int i = 0; i < MSG_DEPTH; i++)
						next_ring[i].acked = ring[i].valid;
				end
				CMD_DEL_ALL:
				begin
					for (int i = 0; i < MSG_DEPTH; i++)
						next_ring[i] = '0;
					next_msg_count = 5'h00;
				end
			endcase
		end
		// storage needs no enable; push after command so event wins
		if (msg_push)
		begin
			// count grows only when a free slot is filled
			if (!next_ring[wr_ptr].valid)
				next_msg_count = next_msg_count + 5'h01;
			// type and number, count always 1
			next_ring[wr_ptr] = '{valid: 1'b1, acked: 1'b0, kind: msg_kind,
				number: msg_number, occurrence: MSG_OCCURRENCE};
			next_wr_ptr = ring_inc(wr_ptr);
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < MSG_DEPTH; i++)
				ring[i] <= '0;
			wr_ptr <= 5'h00;
			msg_count <= 5'h00;
		end
		else
		begin
			ring <= next_ring;
			wr_ptr <= next_wr_ptr;
			msg_count <= next_msg_count;
		end
	end

	// measurement sampling, diagnostics, display and heater
	always_comb
	begin
		if (position_in > POS_MAX)
			next_position = POS_MAX;
		else if (position_in < POS_MIN)
			next_position = POS_MIN;
		else
			next_position = position_in;
		next_step_nm = resolution_nm;
		// recording runs beside object access, never blocking it
		if (!diag_mode)
			next_diag_count = 16'h0000;
		else if (diag_sample)
			next_diag_count = diag_count + 16'h0001;
		else
			next_diag_count = diag_count;
		next_light_timer = light_timer;
		next_light_on = light_on;
		if (key_activity)
		begin
			next_light_timer = 64'h0;
			next_light_on = 1'b1;
		end
		else if (light_timer >= 64'(BACKLIGHT_TIMEOUT - 1))
			next_light_on = 1'b0;
		else
			next_light_timer = light_timer + 64'h1;
		next_heat = heat;
		if (temperature_c < (heater_sel[0] ? HEAT_EXT_ON_C : HEAT_STD_ON_C))
			next_heat = 1'b1;
		else if (temperature_c > (heater_sel[0] ? HEAT_EXT_OFF_C : HEAT_STD_OFF_C))
			next_heat = 1'b0;
		next_vel_hold = velocity_fault ? vel_hold : velocity_in;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			position <= 32'sh0;
			step_nm <= 32'h0;
			diag_count <= 16'h0000;
			light_timer <= 64'h0;
			light_on <= 1'b1;
			heat <= 1'b0;
			vel_hold <= 32'sh0;
		end
		else
		begin
			position <= next_position;
			step_nm <= next_step_nm;
			diag_count <= next_diag_count;
			light_timer <= next_light_timer;
			light_on <= next_light_on;
			heat <= next_heat;
			vel_hold <= next_vel_hold;
		end
	end

	// read path
	always_comb
	begin
		next_rvalid = req.rd;
		next_rdata = 32'h0;
		if (req.rd)
		begin
			if (match(req, IDX_FAULT, SUB_VEL_FAULT))
				next_rdata = {24'h0, vel_fault};
			else if (match(req, IDX_LANGUAGE, SUB_LANGUAGE))
				next_rdata = {24'h0, lang_r};
			else if (match(req, IDX_LANGUAGE, SUB_BACKLIGHT))
				next_rdata = {24'h0, backlight};
			else if (match(req, IDX_LANGUAGE, SUB_CONTRAST))
				next_rdata = {24'h0, contrast_r};
			else if (match(req, IDX_LANGUAGE, SUB_PW_ENABLE))
				next_rdata = {24'h0, pw_enable};
			else if (match(req, IDX_LANGUAGE, SUB_PW_VALUE))
				next_rdata = {16'h0, pw_value};
			else if (match(req, IDX_LANGUAGE, SUB_HEATER))
				next_rdata = {24'h0, heater_sel};
			else if (match(req, IDX_OPERATING, 8'h00))
				next_rdata = {16'h0, op_param};
			else if (match(req, IDX_OP_STATUS, 8'h00))
				next_rdata = {16'h0, op_param & OP_MASK};
			else if (match(req, IDX_POSITION, 8'h00))
				next_rdata = position;
			else if (match(req, IDX_STEP_NM, 8'h00))
				next_rdata = step_nm;
			else if (match(req, IDX_MSG, SUB_MSG_COUNT))
				next_rdata = {27'h0, msg_count};
			else if (match(req, IDX_DIAG, SUB_DIAG_MODE))
				next_rdata = {31'h0, diag_mode};
			else if (match(req, IDX_DIAG, SUB_DIAG_COUNT))
				next_rdata = {16'h0, diag_count};
			else if (req.index == IDX_MSG && req.sub >= SUB_MSG_FIRST
				&& req.sub < SUB_MSG_FIRST + 8'(MSG_DEPTH))
				next_rdata = {8'h0, ring[5'(req.sub - SUB_MSG_FIRST)]};
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rdata <= 32'h0;
			rvalid <= 1'b0;
		end
		else
		begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// zero or held value on fault
	assign velocity_out = !velocity_fault ? vel_hold
		: (vel_fault[VF_LAST_ZERO_BIT] ? 32'sh0 : vel_hold);
	assign velocity_status = velocity_fault && !vel_fault[VF_SUPPRESS_BIT]
		&& (!vel_fault[VF_DELAY_BIT] || fault_delay_done);
	assign count_negative = op_param[DIR_BIT];
	assign language = lang_r[2:0];
	assign backlight_on = backlight[0] | light_on;
	assign contrast = contrast_r[1:0];
	assign password_required = pw_enable[0];
	assign password = pw_enable[0] ? pw_value : 16'h0000;
	assign heater_on = HEATER_FITTED & heat;
endmodule : sensor_config_object_bank
`default_nettype wire

// [sim/sensor_config_object_bank_properties.sv]
// assertion checker on the object bank ports
`timescale 1ns/1ps
`default_nettype none
module sensor_config_object_bank_properties
	import sensor_config_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire obj_req_t req,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic wr_error,
	input wire logic count_negative,
	input wire logic [2:0] language,
	input wire logic [1:0] contrast,
	input wire logic password_required,
	input wire logic [15:0] password
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_wr(logic [15:0] i, logic [7:0] s);
		req.wr && req.index == i && req.sub == s;
	endsequence
	sequence s_rd_status;
		req.rd && !req.wr && req.index == IDX_OP_STATUS && req.sub == 8'h00;
	endsequence
	a_read_answered:
	assert property (req.rd |=> rvalid) else $error("read not answered");
	a_no_stray_answer:
	assert property (!req.rd |=> !rvalid) else $error("answer without read");
	a_lang_taken:
	assert property (s_wr(IDX_LANGUAGE, SUB_LANGUAGE) ##0 req.wdata <= 32'h4
		|=> language == $past(req.wdata[2:0])) else $error("language not taken");
	a_lang_refused:
	assert property (s_wr(IDX_LANGUAGE, SUB_LANGUAGE) ##0 req.wdata > 32'h4
		|=> wr_error && $stable(language)) else $error("bad language kept");
	a_contrast_refused:
	assert property (s_wr(IDX_LANGUAGE, SUB_CONTRAST) ##0 req.wdata > 32'h2
		|=> wr_error && $stable(contrast)) else $error("bad contrast kept");
	a_vf_refused:
	assert property (s_wr(IDX_FAULT, SUB_VEL_FAULT) ##0 req.wdata > 32'hD
		|=> wr_error) else $error("bad fault byte accepted");
	a_reset_state:
	assert property ($past(sys_rst) |-> contrast == 2'h1 && language == 3'h0
		&& !password_required) else $error("wrong state after reset");
	a_pw_gated:
	assert property (!password_required |-> password == 16'h0000) else $error("password leaks");
	a_pw_range:
	assert property (password <= PW_MAX) else $error("password out of range");
	a_dir_taken:
	assert property (s_wr(IDX_OPERATING, 8'h00)
		|=> count_negative == $past(req.wdata[DIR_BIT])) else $error("direction not taken");
	a_mirror_read:
	assert property (s_rd_status |=> rdata == {28'h0, count_negative, 3'h0})
		else $error("status word does not mirror");
endmodule : sensor_config_object_bank_properties
`default_nettype wire

// [sim/fieldbus_master_model.sv]
// fieldbus master model issuing object requests
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model
	import sensor_config_pkg::*;
(
	input wire logic clk,
	output var obj_req_t req,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic wr_error
);
	initial
		req = '0;
	task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] v, output logic [31:0] d, output logic e);
		@(negedge clk);
		req = '{wr: w, rd: !w, index: i, sub: s, wdata: v};
		@(negedge clk);
		d = rdata;
		e = wr_error;
		// released fields show a changed pattern
		req = '{wr: 1'b0, rd: 1'b0, index: ~i, sub: ~s, wdata: ~v};
	endtask : xfer
endmodule : fieldbus_master_model
`default_nettype wire

// [sim/tb_sensor_config_object_bank.sv]
// self-checking bench for the object bank
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_config_object_bank
	import sensor_config_pkg::*;
;
	logic clk, sys_rst, vfault, fdone, push, key, dsamp, rvalid, wr_error, e, ok;
	logic neg, bl_on, pw_req, heat, vstat;
	logic signed [31:0] pos, vel, vout;
	logic [31:0] res, rdata, d, v;
	logic [11:0] num;
	logic [7:0] temp;
	logic [2:0] lang;
	logic [1:0] con;
	logic [15:0] pw;
	msg_type_t kind;
	obj_req_t req;
	int n_errors = 0;
	int n_checks = 0;
	int seed = 32'hd146;
	int i, k;
	logic [31:0] mx [7] = '{32'h4, 32'h1, 32'h2, 32'h1, 32'h270F, 32'h1, 32'hD};
	logic [31:0] cur [7] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'hD};
	logic signed [31:0] pc [4] = '{32'sd999999, -32'sd999999, 32'sd1000000, -32'sd1000001};
	sensor_config_object_bank #(.BACKLIGHT_TIMEOUT(20), .HEATER_FITTED(1'b1)) dut (
		.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .rvalid(rvalid),
		.wr_error(wr_error), .position_in(pos), .resolution_nm(res), .velocity_fault(vfault),
		.velocity_in(vel), .fault_delay_done(fdone), .msg_push(push), .msg_kind(kind),
		.msg_number(num), .key_activity(key), .temperature_c(temp), .diag_sample(dsamp),
		.velocity_out(vout), .velocity_status(vstat), .count_negative(neg), .language(lang),
		.backlight_on(bl_on), .contrast(con), .password_required(pw_req), .password(pw),
		.heater_on(heat));
	fieldbus_master_model master (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid),
		.wr_error(wr_error));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x,
		input logic ee);
		master.xfer(1'b1, i, s, x, d, e);
		check(32'(e), 32'(ee));
	endtask : wr
	task automatic rdc(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
		master.xfer(1'b0, i, s, 32'h0, d, e);
		check(d, x);
	endtask : rdc
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic do_reset();
		sys_rst = 1'b1;
		cyc(3);
		sys_rst = 1'b0;
	endtask : do_reset
	function automatic logic [15:0] idx_of(input int n);
		return (n < 6) ? IDX_LANGUAGE : IDX_FAULT;
	endfunction : idx_of
	function automatic logic [7:0] sub_of(input int n);
		return (n < 6) ? 8'(n + 1) : SUB_VEL_FAULT;
	endfunction : sub_of
	function automatic logic [31:0] clamp(input logic signed [31:0] p);
		return (p > POS_MAX) ? POS_MAX : ((p < POS_MIN) ? POS_MIN : p);
	endfunction : clamp
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#400000;
		n_errors++;
		end_of_test();
	end
	initial
	begin
		{sys_rst, vfault, fdone, push, key, dsamp} = 6'h20;
		{pos, vel, num, temp} = '0;
		kind = MSG_INFO;
		res = 32'd1000000;
		do_reset();
		for (i = 0; i < 7; i++)
			rdc(idx_of(i), sub_of(i), cur[i]);
		repeat (60)
		begin
			k = {$random(seed)} % 7;
			v = {$random(seed)} % (mx[k] + 3);
			ok = v <= mx[k];
			wr(idx_of(k), sub_of(k), v, !ok);
			if (ok)
				cur[k] = (k == 6) ? (v & 32'(VF_MASK)) : v;
			rdc(idx_of(k), sub_of(k), cur[k]);
			check(32'({lang, con}), 32'({cur[0][2:0], cur[2][1:0]}));
		end
		wr(IDX_LANGUAGE, SUB_PW_VALUE, 32'd10000, 1'b1);
		wr(16'h1234, 8'h00, 32'h5, 1'b1);
		rdc(16'h1234, 8'h00, 32'h0);
		$display("test ranges done");
		wr(IDX_LANGUAGE, SUB_PW_VALUE, 32'd1234, 1'b0);
		wr(IDX_LANGUAGE, SUB_PW_ENABLE, 32'h0, 1'b0);
		check(32'({pw_req, pw}), 32'h0);
		wr(IDX_LANGUAGE, SUB_PW_ENABLE, 32'h1, 1'b0);
		check(32'({pw_req, pw}), 32'h104D2);
		for (i = 0; i < 4; i++)
		begin
			v = $random(seed);
			wr(IDX_OPERATING, 8'h00, v, 1'b0);
			rdc(IDX_OPERATING, 8'h00, v & 32'h8);
			rdc(IDX_OP_STATUS, 8'h00, v & 32'h8);
			check(32'(neg), 32'(v[3]));
		end
		for (i = 0; i < 8; i++)
		begin
			pos = (i < 4) ? pc[i] : $random(seed) % 1100000;
			rdc(IDX_POSITION, 8'h00, clamp(pos));
		end
		rdc(IDX_STEP_NM, 8'h00, 32'd1000000);
		$display("test pass-through done");
		wr(IDX_FAULT, SUB_VEL_FAULT, 32'h1, 1'b0);
		vel = 32'sd777;
		cyc(2);
		vfault = 1'b1;
		cyc(2);
		check(vout, 32'h0);
		wr(IDX_FAULT, SUB_VEL_FAULT, 32'h0, 1'b0);
		vfault = 1'b0;
		cyc(2);
		vel = -32'sd55;
		vfault = 1'b1;
		cyc(2);
		check(vout, 32'sd777);
		check(32'(vstat), 32'h1);
		wr(IDX_FAULT, SUB_VEL_FAULT, 32'h4, 1'b0);
		check(32'(vstat), 32'h0);
		wr(IDX_FAULT, SUB_VEL_FAULT, 32'h8, 1'b0);
		check(32'(vstat), 32'h0);
		fdone = 1'b1;
		cyc(1);
		check(32'(vstat), 32'h1);
		fdone = 1'b0;
		vfault = 1'b0;
		cyc(1);
		check(32'(vstat), 32'h0);
		for (i = 0; i < 4; i++)
		begin
			wr(IDX_LANGUAGE, SUB_HEATER, 32'(i / 2), 1'b0);
			temp = (i == 0) ? 8'd5 : (i == 1) ? 8'd20 : (i == 2) ? 8'd25 : 8'd40;
			cyc(3);
			check(32'(heat), 32'(i % 2 == 0));
		end
		wr(IDX_LANGUAGE, SUB_BACKLIGHT, 32'h0, 1'b0);
		key = 1'b1;
		cyc(1);
		key = 1'b0;
		cyc(25);
		check(32'(bl_on), 32'h0);
		wr(IDX_LANGUAGE, SUB_BACKLIGHT, 32'h1, 1'b0);
		cyc(30);
		check(32'(bl_on), 32'h1);
		$display("test outputs done");
		for (i = 0; i < 27; i++)
		begin
			push = 1'b1;
			kind = msg_type_t'(i % 4);
			num = 12'(i);
			cyc(1);
		end
		push = 1'b0;
		rdc(IDX_MSG, SUB_MSG_COUNT, 32'd25);
		master.xfer(1'b0, IDX_MSG, SUB_MSG_FIRST + 8'h01, 32'h0, d, e);
		check(32'({d[23], d[21:0]}), 32'({1'b1, MSG_ERROR, 12'd26, MSG_OCCURRENCE}));
		wr(IDX_MSG, SUB_MSG_CMD, {22'h0, CMD_ACK_ONE, 8'h05}, 1'b0);
		master.xfer(1'b0, IDX_MSG, SUB_MSG_FIRST + 8'h05, 32'h0, d, e);
		check(32'({d[22], d[7:0]}), 32'h101);
		wr(IDX_MSG, SUB_MSG_CMD, {22'h0, CMD_DEL_ONE, 8'h03}, 1'b0);
		rdc(IDX_MSG, SUB_MSG_COUNT, 32'd24);
		wr(IDX_MSG, SUB_MSG_CMD, {22'h0, CMD_ACK_ALL, 8'h00}, 1'b0);
		master.xfer(1'b0, IDX_MSG, SUB_MSG_FIRST + 8'h06, 32'h0, d, e);
		check(32'(d[22]), 32'h1);
		wr(IDX_MSG, SUB_MSG_CMD, {22'h0, CMD_DEL_ALL, 8'h00}, 1'b0);
		rdc(IDX_MSG, SUB_MSG_COUNT, 32'd0);
		wr(IDX_DIAG, SUB_DIAG_MODE, 32'h1, 1'b0);
		dsamp = 1'b1;
		rdc(IDX_STEP_NM, 8'h00, 32'd1000000);
		dsamp = 1'b0;
		rdc(IDX_DIAG, SUB_DIAG_COUNT, 32'd2);
		wr(IDX_DIAG, SUB_DIAG_MODE, 32'h0, 1'b0);
		rdc(IDX_DIAG, SUB_DIAG_COUNT, 32'd0);
		push = 1'b1;
		cyc(1);
		push = 1'b0;
		do_reset();
		rdc(IDX_MSG, SUB_MSG_COUNT, 32'd0);
		$display("test messages done");
		end_of_test();
	end
endmodule : tb_sensor_config_object_bank
bind sensor_config_object_bank sensor_config_object_bank_properties chk (
	.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .rvalid(rvalid),
	.wr_error(wr_error), .count_negative(count_negative), .language(language),
	.contrast(contrast), .password_required(password_required), .password(password));
`default_nettype wire
